// *** src/edtu_defs.vh ***
// Offsets, field positions, reset values and codes of the debug trigger unit
`ifndef EDTU_DEFS_VH
`define EDTU_DEFS_VH
// =====================================================
// Register byte offsets (9-bit Wishbone address)
`define EDTU_CTRL       9'h000
`define EDTU_STATUS     9'h004
`define EDTU_IRQ_STAT   9'h008
`define EDTU_IRQ_MASK   9'h00c
`define EDTU_CLKRUN     9'h010
`define EDTU_ACTION     9'h014
`define EDTU_SEQCFG     9'h018
`define EDTU_SEQTR_BASE 5'h02
`define EDTU_RTRG_BASE  4'h2
`define EDTU_COMB_BASE  4'h3
`define EDTU_MTRG_BASE  2'h1
`define EDTU_TRACE_BASE 3'h4
// Field offsets inside one trigger slot
`define EDTU_F_REF      2'h0
`define EDTU_F_MASK     2'h1
`define EDTU_F_CFG      2'h2
// =====================================================
// Control bits
`define EDTU_CTRL_RELEASE 1
`define EDTU_CTRL_BYTEMSK 2
`define EDTU_CTRL_STOREN  3
`define EDTU_CTRL_STORCLR 4
`define EDTU_CTRL_SEQEN   5
// Action routing fields
`define EDTU_ACT_SEQBRK   16
`define EDTU_ACT_SEQSTO   17
// Sequencer reset trigger enable
`define EDTU_SEQ_RSTEN    3
// Interrupt status bits
`define EDTU_IRQ_BRK      0
`define EDTU_IRQ_SEQ      1
`define EDTU_IRQ_FULL     2
// =====================================================
// Comparison operators
`define EDTU_OP_EQ 2'h0
`define EDTU_OP_NE 2'h1
`define EDTU_OP_GE 2'h2
`define EDTU_OP_LE 2'h3
// Reset values and trace depth
`define EDTU_RST_MASK   20'hfffff
`define EDTU_RST_CLKRUN 8'h00
`define EDTU_TRACE_DEPTH 4'h8
`endif

// *** src/edtu_cmp.v ***
// Masked four-operator comparator used by every simple trigger
`timescale 1ns/1ns
`default_nettype none
`include "edtu_defs.vh"
module edtu_cmp
(
  input  wire [19:0] val_i,   // Observed value
  input  wire [19:0] ref_i,   // Programmed reference
  input  wire [19:0] mask_i,  // One selects a compared bit
  input  wire [1:0]  op_i,    // Operator code
  input  wire        qual_i,  // Qualified cycle
  output wire        hit_o    // Trigger for this cycle
);
  // =====================================================
  // Comparison
  wire [19:0] mv = val_i & mask_i;  // Masked value
  wire [19:0] mr = ref_i & mask_i;  // Masked reference
  reg         match;                // Operator result

  // Select operator
  always @*
  begin
    case (op_i)
      `EDTU_OP_EQ: match = (mv == mr);
      `EDTU_OP_NE: match = (mv != mr);
      `EDTU_OP_GE: match = (mv >= mr);
      default:     match = (mv <= mr);
    endcase
  end

  // Only a qualified bus or register write cycle can fire
  assign hit_o = qual_i & match;
endmodule // edtu_cmp
`default_nettype wire

// *** src/edtu_top.v ***
// Debug trigger unit: triggers, sequencer, trace store, clock control
// Operation
// - Debugger reaches unit only via JTAG port
// - Memory trigger compares address or data bus
// - Memory operators: equal, unequal, at or above, at or below
// - Memory mask bit-wise or byte-wise
// - Memory trigger qualified by access type
// - Register trigger watches selected CPU register
// - Register operators four kinds, bit masked
// - Triggers combine into complex triggers
// - Triggers route to stop, storage, sequencer
// - Sequencer has four states zero to three
// - Two programmable transitions in states zero to two
// - Reset trigger returns sequencer to zero
// - Start at zero, act at three
// - Trace stores bus and type, eight entries
// - Stop halts some clocks, keeps others
// - Full mask covers all bus bits
// - Eight memory and two register triggers
// - Up to eight combination triggers
`timescale 1ns/1ns
`default_nettype none
`include "edtu_defs.vh"
module edtu_top
(
  input  wire        clk_i,          // CPU clock
  input  wire        rst_i,          // Synchronous reset, high
  input  wire        wb_cyc_i,       // Wishbone cycle from JTAG bridge
  input  wire        wb_stb_i,       // Wishbone strobe
  input  wire        wb_we_i,        // Write enable
  input  wire [8:0]  wb_adr_i,       // Byte address
  input  wire [3:0]  wb_sel_i,       // Byte lanes
  input  wire [31:0] wb_dat_i,       // Write data
  output reg  [31:0] wb_dat_o,       // Read data
  output wire        wb_ack_o,       // Acknowledge
  input  wire [19:0] mab_i,          // mem_addr_bus
  input  wire [15:0] mdb_i,          // mem_data_bus
  input  wire        bus_valid_i,    // Bus cycle in progress
  input  wire        bus_rd_i,       // Read access
  input  wire        bus_wr_i,       // Write access
  input  wire        bus_dma_i,      // DMA access
  input  wire        bus_fetch_i,    // Instruction fetch
  input  wire        reg_wr_i,       // CPU register write
  input  wire [3:0]  reg_wr_sel_i,   // Register number written
  input  wire [19:0] reg_wr_data_i,  // Value written
  output reg         cpu_stop_o,     // Emulation stop request
  output reg  [7:0]  mod_clk_en_o,   // Per-module clock enables
  output reg         irq_o           // Level interrupt
);
  // =====================================================
  // Sequencer states
  localparam [3:0] S0 = 4'b0001;
  localparam [3:0] S1 = 4'b0010;
  localparam [3:0] S2 = 4'b0100;
  localparam [3:0] S3 = 4'b1000;

  // =====================================================
  // Configuration storage
  reg [19:0] mref_r [0:7];    // Memory trigger references
  reg [19:0] mmask_r [0:7];   // Memory trigger masks
  reg [6:0]  mcfg_r [0:7];    // Bus select, operator, access enables
  reg [19:0] rref_r [0:1];    // Register trigger references
  reg [19:0] rmask_r [0:1];   // Register trigger masks
  reg [7:0]  rcfg_r [0:1];    // Operator, register select
  reg [9:0]  comb_cfg_r [0:7];// Trigger sets combined per complex trigger
  reg [13:0] seqtr_r [0:3];   // Two transitions per state
  reg [5:0]  ctrl_r;          // Control bits
  reg [2:0]  irq_mask_r;      // Interrupt mask
  reg [2:0]  irq_stat_r;      // Sticky interrupt status
  reg [7:0]  clkrun_r;        // Modules kept running at stop
  reg [17:0] action_r;        // Reaction routing
  reg [3:0]  seqcfg_r;        // Reset trigger select
  reg        ack_r;           // Bus acknowledge

  // Trace buffer
  reg [22:0] tr_a_r [0:7];    // Type and address per entry
  reg [15:0] tr_d_r [0:7];    // Data per entry
  reg [3:0]  tr_cnt_r;        // Entries held

  // Pipeline and state
  reg [9:0]  trig_r;          // Registered simple triggers
  reg [7:0]  comb_r;          // Complex trigger hits
  reg [19:0] mab_d_r;         // Bus copy aligned with comb_r
  reg [15:0] mdb_d_r;
  reg [2:0]  typ_d_r;
  reg [19:0] mab_q_r;         // Bus copy aligned with trig_r
  reg [15:0] mdb_q_r;
  reg [2:0]  typ_q_r;
  reg [3:0]  seq_r;           // Sequencer state, one-hot
  reg [3:0]  seq_nxt;

  // =====================================================
  // Functions
  // Byte-granular mode widens two mask bits over the bus
  function [19:0] eff_mask;
    input [19:0] m;
    input        byte_mode;
    begin
      eff_mask = byte_mode ? {{12{m[1]}}, {8{m[0]}}} : m;
    end
  endfunction

  // Two-bit state number to one-hot
  function [3:0] to_hot;
    input [1:0] n;
    begin
      to_hot = 4'h1 << n;
    end
  endfunction

  // =====================================================
  // Wishbone decode, one-cycle answer
  wire        req = wb_cyc_i & wb_stb_i & ~ack_r;  // New request
  wire        wr  = req & wb_we_i;                 // Write this edge
  wire [31:0] selm = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [2:0]  mi  = wb_adr_i[6:4];                 // Memory trigger index
  wire        ri  = wb_adr_i[4];                   // Register trigger index
  wire [1:0]  fld = wb_adr_i[3:2];                 // Slot field
  wire        in_m = (wb_adr_i[8:7] == `EDTU_MTRG_BASE);
  wire        in_r = (wb_adr_i[8:5] == `EDTU_RTRG_BASE);
  wire        in_c = (wb_adr_i[8:5] == `EDTU_COMB_BASE);
  wire        in_s = (wb_adr_i[8:4] == `EDTU_SEQTR_BASE);
  wire        in_t = (wb_adr_i[8:6] == `EDTU_TRACE_BASE);
  reg  [31:0] rd_nxt;                              // Current value at address
  wire [31:0] wval = (rd_nxt & ~selm) | (wb_dat_i & selm);  // Byte-merged write
  wire        release_p = wr && (wb_adr_i == `EDTU_CTRL) && wval[`EDTU_CTRL_RELEASE];
  wire        clear_p   = wr && (wb_adr_i == `EDTU_CTRL) && wval[`EDTU_CTRL_STORCLR];

  assign wb_ack_o = ack_r;

  // Read mux, unmapped reads return zero
  always @*
  begin
    rd_nxt = 32'h0;
    if (wb_adr_i == `EDTU_CTRL)
      rd_nxt = {26'h0, ctrl_r};
    else if (wb_adr_i == `EDTU_STATUS)
      rd_nxt = {24'h0, tr_cnt_r, seq_r[3:1] != 3'h0 ? {seq_r[3] | seq_r[2], seq_r[3] | seq_r[1]} : 2'h0,
                1'b0, cpu_stop_o};
    else if (wb_adr_i == `EDTU_IRQ_STAT)
      rd_nxt = {29'h0, irq_stat_r};
    else if (wb_adr_i == `EDTU_IRQ_MASK)
      rd_nxt = {29'h0, irq_mask_r};
    else if (wb_adr_i == `EDTU_CLKRUN)
      rd_nxt = {24'h0, clkrun_r};
    else if (wb_adr_i == `EDTU_ACTION)
      rd_nxt = {14'h0, action_r};
    else if (wb_adr_i == `EDTU_SEQCFG)
      rd_nxt = {28'h0, seqcfg_r};
    else if (in_s)
      rd_nxt = {18'h0, seqtr_r[wb_adr_i[3:2]]};
    else if (in_c)
      rd_nxt = {22'h0, comb_cfg_r[wb_adr_i[4:2]]};
    else if (in_r && fld == `EDTU_F_REF)
      rd_nxt = {12'h0, rref_r[ri]};
    else if (in_r && fld == `EDTU_F_MASK)
      rd_nxt = {12'h0, rmask_r[ri]};
    else if (in_r && fld == `EDTU_F_CFG)
      rd_nxt = {24'h0, rcfg_r[ri]};
    else if (in_m && fld == `EDTU_F_REF)
      rd_nxt = {12'h0, mref_r[mi]};
    else if (in_m && fld == `EDTU_F_MASK)
      rd_nxt = {12'h0, mmask_r[mi]};
    else if (in_m && fld == `EDTU_F_CFG)
      rd_nxt = {25'h0, mcfg_r[mi]};
    else if (in_t && !wb_adr_i[2])
      rd_nxt = {9'h0, tr_a_r[wb_adr_i[5:3]]};
    else if (in_t)
      rd_nxt = {16'h0, tr_d_r[wb_adr_i[5:3]]};
  end

  // Acknowledge and read data register; reach is via JTAG bridge only
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r    <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      ack_r <= req;
      // Read data holds across writes until the next taken read
      if (req & ~wb_we_i)
        wb_dat_o <= rd_nxt;
    end
  end

  // Configuration writes
  integer k;
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (k = 0; k < 8; k = k + 1)
      begin
        mref_r[k]     <= 20'h0;
        mmask_r[k]    <= `EDTU_RST_MASK;
        mcfg_r[k]     <= 7'h0;
        comb_cfg_r[k] <= 10'h0;
      end
      for (k = 0; k < 2; k = k + 1)
      begin
        rref_r[k]  <= 20'h0;
        rmask_r[k] <= `EDTU_RST_MASK;
        rcfg_r[k]  <= 8'h0;
      end
      for (k = 0; k < 4; k = k + 1)
        seqtr_r[k] <= 14'h0;
      ctrl_r     <= 6'h0;
      irq_mask_r <= 3'h0;
      clkrun_r   <= `EDTU_RST_CLKRUN;
      action_r   <= 18'h0;
      seqcfg_r   <= 4'h0;
    end
    else if (wr)
    begin
      // Release and clear are pulses and never stored
      if (wb_adr_i == `EDTU_CTRL)
        ctrl_r <= wval[5:0] & 6'h2c;
      else if (wb_adr_i == `EDTU_IRQ_MASK)
        irq_mask_r <= wval[2:0];
      else if (wb_adr_i == `EDTU_CLKRUN)
        clkrun_r <= wval[7:0];
      else if (wb_adr_i == `EDTU_ACTION)
        action_r <= wval[17:0];
      else if (wb_adr_i == `EDTU_SEQCFG)
        seqcfg_r <= wval[3:0];
      else if (in_s)
        seqtr_r[wb_adr_i[3:2]] <= wval[13:0] & 14'h3f3f;  // Bits 7:6 reserved
      else if (in_c)
        comb_cfg_r[wb_adr_i[4:2]] <= wval[9:0];
      else if (in_r && fld == `EDTU_F_REF)
        rref_r[ri] <= wval[19:0];
      else if (in_r && fld == `EDTU_F_MASK)
        rmask_r[ri] <= wval[19:0];
      else if (in_r && fld == `EDTU_F_CFG)
        rcfg_r[ri] <= wval[7:0];
      else if (in_m && fld == `EDTU_F_REF)
        mref_r[mi] <= wval[19:0];
      else if (in_m && fld == `EDTU_F_MASK)
        mmask_r[mi] <= wval[19:0];
      else if (in_m && fld == `EDTU_F_CFG)
        mcfg_r[mi] <= wval[6:0];
    end
  end

  // =====================================================
  // Simple triggers
  wire [9:0] trig;                 // Raw trigger hits this cycle
  wire [3:0] acc = {bus_fetch_i, bus_dma_i, bus_wr_i, bus_rd_i};
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_mem
      edtu_cmp u_cmp
      (
        .val_i  (mcfg_r[g][0] ? {4'h0, mdb_i} : mab_i),
        .ref_i  (mref_r[g]),
        .mask_i (eff_mask(mmask_r[g], ctrl_r[`EDTU_CTRL_BYTEMSK])),
        .op_i   (mcfg_r[g][2:1]),
        .qual_i (bus_valid_i & |(mcfg_r[g][6:3] & acc)),
        .hit_o  (trig[g])
      );
    end
    for (g = 0; g < 2; g = g + 1)
    begin : g_reg
      edtu_cmp u_cmp
      (
        .val_i  (reg_wr_data_i),
        .ref_i  (rref_r[g]),
        .mask_i (rmask_r[g]),
        .op_i   (rcfg_r[g][1:0]),
        .qual_i (reg_wr_i & (reg_wr_sel_i == rcfg_r[g][7:4])),
        .hit_o  (trig[8 + g])
      );
    end
  endgenerate

  // =====================================================
  // Complex triggers: all selected simple triggers together
  integer c;
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      trig_r  <= 10'h0;
      comb_r  <= 8'h0;
      mab_q_r <= 20'h0;
      mdb_q_r <= 16'h0;
      typ_q_r <= 3'h0;
      mab_d_r <= 20'h0;
      mdb_d_r <= 16'h0;
      typ_d_r <= 3'h0;
    end
    else
    begin
      trig_r <= trig;
      for (c = 0; c < 8; c = c + 1)
        comb_r[c] <= (|comb_cfg_r[c]) && ((trig_r & comb_cfg_r[c]) == comb_cfg_r[c]);
      mab_q_r <= mab_i;
      mdb_q_r <= mdb_i;
      typ_q_r <= {bus_fetch_i, bus_wr_i, bus_rd_i};
      mab_d_r <= mab_q_r;
      mdb_d_r <= mdb_q_r;
      typ_d_r <= typ_q_r;
    end
  end

  // =====================================================
  // Sequencer
  reg  [1:0]  cur;                                    // Current state number
  wire [13:0] tr = seqtr_r[cur];                      // Transitions of current state
  wire        seq_rst = seqcfg_r[`EDTU_SEQ_RSTEN] & comb_r[seqcfg_r[2:0]];
  wire        seq_at3 = (seq_r == S3);

  // Next state
  always @*
  begin
    case (seq_r)
      S1:      cur = 2'h1;
      S2:      cur = 2'h2;
      S3:      cur = 2'h3;
      default: cur = 2'h0;
    endcase
    seq_nxt = seq_r;
    if (!ctrl_r[`EDTU_CTRL_SEQEN] || seq_rst)
      seq_nxt = S0;
    else
      case (seq_r)
        S3:      seq_nxt = S0;                        // Rearm after action
        default:
        begin
          if (tr[3] && comb_r[tr[2:0]])
            seq_nxt = to_hot(tr[5:4]);
          else if (tr[11] && comb_r[tr[10:8]])
            seq_nxt = to_hot(tr[13:12]);
        end
      endcase
  end

  // State register, starts at zero
  always @(posedge clk_i)
  begin
    if (rst_i)
      seq_r <= S0;
    else
      seq_r <= seq_nxt;
  end

  // =====================================================
  // Reactions
  wire brk_ev = |(comb_r & action_r[7:0]) | (seq_at3 & action_r[`EDTU_ACT_SEQBRK]);
  wire sto_ev = |(comb_r & action_r[15:8]) | (seq_at3 & action_r[`EDTU_ACT_SEQSTO]);
  wire store  = ctrl_r[`EDTU_CTRL_STOREN] & sto_ev & (tr_cnt_r < `EDTU_TRACE_DEPTH);
  wire full_ev = store & (tr_cnt_r == `EDTU_TRACE_DEPTH - 4'h1);
  wire halt_nxt = brk_ev | (cpu_stop_o & ~release_p);
  wire [2:0] ev = {full_ev, seq_at3, brk_ev & ~cpu_stop_o};

  // Stop, clocks, trace, interrupts
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cpu_stop_o   <= 1'b0;
      mod_clk_en_o <= 8'hff;
      tr_cnt_r     <= 4'h0;
      irq_stat_r   <= 3'h0;
      irq_o        <= 1'b0;
    end
    else
    begin
      // A break in the release cycle wins
      cpu_stop_o   <= halt_nxt;
      mod_clk_en_o <= halt_nxt ? clkrun_r : 8'hff;
      if (clear_p)
        tr_cnt_r <= 4'h0;
      else if (store)
      begin
        tr_a_r[tr_cnt_r[2:0]] <= {typ_d_r, mab_d_r};
        tr_d_r[tr_cnt_r[2:0]] <= mdb_d_r;
        tr_cnt_r <= tr_cnt_r + 4'h1;
      end
      // Write one to clear, new event wins
      if (wr && wb_adr_i == `EDTU_IRQ_STAT)
        irq_stat_r <= (irq_stat_r & ~wval[2:0]) | ev;
      else
        irq_stat_r <= irq_stat_r | ev;
      irq_o <= |(irq_stat_r & irq_mask_r);
    end
  end
endmodule // edtu_top
`default_nettype wire

// *** testbench/edtu_checker.sv ***
// Checker of handshake, stop and clock behaviour of the trigger unit
`timescale 1ns/1ns
`default_nettype none
module edtu_checker
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [8:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [19:0] mab_i,
  input wire logic [15:0] mdb_i,
  input wire logic        bus_valid_i,
  input wire logic        bus_rd_i,
  input wire logic        bus_wr_i,
  input wire logic        bus_dma_i,
  input wire logic        bus_fetch_i,
  input wire logic        reg_wr_i,
  input wire logic [3:0]  reg_wr_sel_i,
  input wire logic [19:0] reg_wr_data_i,
  input wire logic        cpu_stop_o,
  input wire logic [7:0]  mod_clk_en_o,
  input wire logic        irq_o
);
  // ==========================================
  // Helper terms
  wire logic req = wb_cyc_i & wb_stb_i;  // Request present
  wire logic act = bus_valid_i | reg_wr_i;  // Possible trigger cause
  wire logic rel = req & wb_we_i & (wb_adr_i == 9'h000) & wb_dat_i[1];  // Release write
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ==========================================
  // Assertions
  chk_ack_pulse:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  chk_ack_answer:
    assert property (req && !wb_ack_o |=> wb_ack_o) else $error("request not answered next cycle");
  chk_ack_idle:
    assert property (!req |=> !wb_ack_o) else $error("ack without request");
  chk_dat_hold:
    assert property (!wb_ack_o || $past(wb_we_i) |-> $stable(wb_dat_o)) else $error("read data moved");
  chk_stop_hold:
    assert property ($fell(cpu_stop_o) |-> $past(rel, 1) || $past(rel, 2) || $past(rel, 3))
      else $error("stop dropped without release");
  chk_stop_cause:
    assert property ($rose(cpu_stop_o) |-> $past(act, 3) || $past(act, 4) || $past(act, 5))
      else $error("stop without bus or register cause");
  chk_clk_all:
    assert property (!cpu_stop_o && !$past(cpu_stop_o) |-> mod_clk_en_o == 8'hff)
      else $error("clock gated while running");
  chk_reset_vals:
    assert property ($fell(rst_i) |-> !cpu_stop_o && !irq_o && !wb_ack_o && mod_clk_en_o == 8'hff)
      else $error("outputs wrong after reset");
endmodule // edtu_checker
bind edtu_top edtu_checker i_edtu_checker (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .mab_i, .mdb_i, .bus_valid_i, .bus_rd_i, .bus_wr_i,
  .bus_dma_i, .bus_fetch_i, .reg_wr_i, .reg_wr_sel_i, .reg_wr_data_i, .cpu_stop_o, .mod_clk_en_o, .irq_o);
`default_nettype wire

// *** testbench/edtu_probe.sv ***
// Debug probe model: Wishbone master standing in for the JTAG bridge
`timescale 1ns/1ns
`default_nettype none
module edtu_probe
(
  input  wire logic        clk_i,     // CPU clock
  input  wire logic        wb_ack_i,  // Slave acknowledge
  input  wire logic [31:0] wb_dat_i,  // Read data
  output var  logic        wb_cyc_o,  // Cycle
  output var  logic        wb_stb_o,  // Strobe
  output var  logic        wb_we_o,   // Write enable
  output var  logic [8:0]  wb_adr_o,  // Byte address
  output var  logic [3:0]  wb_sel_o,  // Byte lanes
  output var  logic [31:0] wb_dat_o   // Write data
);
  // ==========================================
  // Idle bus from time zero
  initial
  begin
    {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o} = 48'h0;
  end
  // One classic cycle, held until ack is sampled high
  task automatic xfer(input logic w, input logic [8:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o} <= {2'h3, w, a, 4'hf, d};
    do
      @(posedge clk_i);
    while (wb_ack_i !== 1'b1);
    q = wb_dat_i;
    {wb_cyc_o, wb_stb_o, wb_we_o} <= 3'h0;
    // Released lines carry junk, not the last value
    wb_adr_o <= ~a;
    wb_dat_o <= ~d;
  endtask
  // Register write
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  // Register read
  task automatic rd(input logic [8:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask
endmodule // edtu_probe
`default_nettype wire

// *** testbench/edtu_top_tb_top.sv ***
// Self-checking bench of the debug trigger unit
`timescale 1ns/1ns
`default_nettype none
`include "edtu_defs.vh"
module edtu_top_tb_top;
  // ==========================================
  // Signals, clock and instances
  logic        clk_i = 1'b0, rst_i = 1'b1;
  logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, cpu_stop_o, irq_o;
  logic [8:0]  wb_adr_i;
  logic [3:0]  wb_sel_i, reg_wr_sel_i = 4'h0;
  logic [31:0] wb_dat_i, wb_dat_o, ctl;
  logic [19:0] mab_i = 20'h0, reg_wr_data_i = 20'h0;
  logic [15:0] mdb_i = 16'h0;
  logic        bus_valid_i = 1'b0, bus_rd_i = 1'b0, bus_wr_i = 1'b0, bus_dma_i = 1'b0, bus_fetch_i = 1'b0;
  logic        reg_wr_i = 1'b0;
  logic [7:0]  mod_clk_en_o;
  int          fails = 0, cmp_count = 0;
  always #5 clk_i = ~clk_i;
  edtu_top i_edtu_top (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .mab_i, .mdb_i, .bus_valid_i, .bus_rd_i, .bus_wr_i, .bus_dma_i, .bus_fetch_i,
    .reg_wr_i, .reg_wr_sel_i, .reg_wr_data_i, .cpu_stop_o, .mod_clk_en_o, .irq_o);
  edtu_probe i_edtu_probe (.clk_i, .wb_ack_i(wb_ack_o), .wb_dat_i(wb_dat_o), .wb_cyc_o(wb_cyc_i),
    .wb_stb_o(wb_stb_i), .wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i), .wb_sel_o(wb_sel_i), .wb_dat_o(wb_dat_i));
  // ==========================================
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    i_edtu_probe.wr(a, d);
  endtask
  task automatic rc(input logic [8:0] a, input logic [31:0] exp);
    logic [31:0] v;
    i_edtu_probe.rd(a, v);
    check(v, exp);
  endtask
  task automatic do_reset;
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    ctl = 32'h0;
  endtask
  // Wait out the trigger path, check stop, then release and clear if stopped
  task automatic expect_stop(input logic e);
    repeat (6) @(posedge clk_i);
    check(cpu_stop_o, e);
    if (cpu_stop_o === 1'b1)
    begin
      wr(`EDTU_CTRL, ctl | 32'h2);
      wr(`EDTU_IRQ_STAT, 32'h7);
    end
  endtask
  // One bus cycle; k is {fetch, dma, write, read}
  task automatic bus(input logic [19:0] a, input logic [15:0] d, input logic [3:0] k);
    @(posedge clk_i);
    {mab_i, mdb_i, bus_fetch_i, bus_dma_i, bus_wr_i, bus_rd_i, bus_valid_i} <= {a, d, k, 1'b1};
    @(posedge clk_i);
    {bus_fetch_i, bus_dma_i, bus_wr_i, bus_rd_i, bus_valid_i} <= 5'h0;
    mab_i <= ~a;
  endtask
  task automatic hit(input logic [19:0] a, input logic [15:0] d, input logic [3:0] k, input logic e);
    bus(a, d, k);
    expect_stop(e);
  endtask
  task automatic rhit(input logic [3:0] s, input logic [19:0] v, input logic e);
    @(posedge clk_i);
    {reg_wr_sel_i, reg_wr_data_i, reg_wr_i} <= {s, v, 1'b1};
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    expect_stop(e);
  endtask
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==========================================
  // Watchdog
  initial
  begin
    #400000;
    fails++;
    report_and_stop();
  end
  // ==========================================
  // Test sequence
  initial
  begin
    do_reset();
    rc(9'h084, 32'hfffff);
    rc(`EDTU_STATUS, 32'h0);
    wr(9'h1fc, 32'hffffffff);
    rc(9'h1fc, 32'h0);
    // Operators, clock control and interrupt
    wr(`EDTU_CLKRUN, 32'h5a);
    wr(`EDTU_ACTION, 32'h1);
    wr(`EDTU_IRQ_MASK, 32'h1);
    wr(9'h060, 32'h1);
    wr(9'h080, 32'h100);
    wr(9'h088, 32'h8);
    bus(20'h100, 16'h0, 4'h1);
    repeat (6) @(posedge clk_i);
    check(mod_clk_en_o, 32'h5a);
    check(irq_o, 32'h1);
    wr(`EDTU_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk_i);
    check(irq_o, 32'h0);
    wr(`EDTU_IRQ_MASK, 32'h1);
    wr(`EDTU_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clk_i);
    check(irq_o, 32'h0);
    rc(`EDTU_STATUS, 32'h1);
    wr(`EDTU_CTRL, 32'h2);
    repeat (2) @(posedge clk_i);
    check(mod_clk_en_o, 32'hff);
    for (int op = 0; op < 4; op++)
    begin
      wr(9'h088, 32'h8 | (op << 1));
      for (int d = -1; d < 2; d++)
        hit(20'(256 + d), 16'h0, 4'h1, op == 0 ? d == 0 : op == 1 ? d != 0 : op == 2 ? d >= 0 : d <= 0);
    end
    // Access qualification, masks, data bus and combination
    wr(9'h080, 32'h200);
    for (int j = 0; j < 4; j++)
    begin
      wr(9'h088, 32'h8 << j);
      for (int k = 0; k < 4; k++)
        hit(20'h200, 16'h0, 4'(1 << k), j == k);
    end
    wr(9'h084, 32'hffff0);
    hit(20'h20f, 16'h0, 4'h8, 1'b1);
    hit(20'h21f, 16'h0, 4'h8, 1'b0);
    ctl = 32'h4;
    wr(`EDTU_CTRL, ctl);
    wr(9'h084, 32'h1);
    hit(20'h45600, 16'h0, 4'h8, 1'b1);
    hit(20'h201, 16'h0, 4'h8, 1'b0);
    do_reset();
    wr(`EDTU_ACTION, 32'h1);
    wr(9'h060, 32'h3);
    wr(9'h080, 32'h200);
    wr(9'h088, 32'h10);
    wr(9'h090, 32'h1234);
    wr(9'h098, 32'h11);
    hit(20'h200, 16'h1111, 4'h2, 1'b0);
    hit(20'h204, 16'h1234, 4'h2, 1'b0);
    hit(20'h200, 16'h1234, 4'h2, 1'b1);
    // Register write triggers
    wr(9'h060, 32'h100);
    wr(9'h040, 32'h55);
    wr(9'h048, 32'h50);
    rhit(4'h4, 20'h55, 1'b0);
    rhit(4'h5, 20'h55, 1'b1);
    wr(9'h048, 32'h53);
    rhit(4'h5, 20'h56, 1'b0);
    rhit(4'h5, 20'h54, 1'b1);
    // Unequal operator with only bits 7:4 compared
    wr(9'h048, 32'h51);
    wr(9'h044, 32'hf0);
    rhit(4'h5, 20'h5a, 1'b0);
    rhit(4'h5, 20'h65, 1'b1);
    wr(9'h060, 32'h200);
    wr(9'h050, 32'h7);
    wr(9'h058, 32'h20);
    rhit(4'h2, 20'h7, 1'b1);
    // Sequencer: 0 -A-> 1 -B-> 2 -A-> 3, state 0 -B-> 3, reset on third trigger
    do_reset();
    for (int i = 0; i < 3; i++)
    begin
      wr(9'(9'h080 + 16 * i), 32'h300 + i);
      wr(9'(9'h088 + 16 * i), 32'h8);
      wr(9'(9'h060 + 4 * i), 32'h1 << i);
    end
    wr(9'h020, 32'h3918);
    wr(9'h024, 32'h29);
    wr(9'h028, 32'h38);
    wr(`EDTU_SEQCFG, 32'ha);
    wr(`EDTU_ACTION, 32'h10000);
    ctl = 32'h20;
    wr(`EDTU_CTRL, ctl);
    hit(20'h300, 16'h0, 4'h1, 1'b0);
    rc(`EDTU_STATUS, 32'h4);
    hit(20'h302, 16'h0, 4'h1, 1'b0);
    rc(`EDTU_STATUS, 32'h0);
    hit(20'h301, 16'h0, 4'h1, 1'b1);
    hit(20'h300, 16'h0, 4'h1, 1'b0);
    hit(20'h301, 16'h0, 4'h1, 1'b0);
    rc(`EDTU_STATUS, 32'h8);
    // Last step to state three: break and sequencer events both flagged
    bus(20'h300, 16'h0, 4'h1);
    repeat (6) @(posedge clk_i);
    check(cpu_stop_o, 32'h1);
    rc(`EDTU_IRQ_STAT, 32'h3);
    // Trace store fills at eight entries
    do_reset();
    wr(9'h084, 32'h0);
    wr(9'h088, 32'h48);
    wr(9'h060, 32'h1);
    wr(`EDTU_ACTION, 32'h100);
    ctl = 32'h8;
    wr(`EDTU_CTRL, ctl);
    for (int n = 0; n < 10; n++)
      bus(20'(n), 16'(160 + n), 4'h8);
    repeat (6) @(posedge clk_i);
    check(cpu_stop_o, 32'h0);
    rc(`EDTU_STATUS, 32'h80);
    rc(`EDTU_IRQ_STAT, 32'h4);
    for (int n = 0; n < 8; n++)
    begin
      rc(9'(9'h100 + 8 * n), 32'h400000 + n);
      rc(9'(9'h104 + 8 * n), 32'ha0 + n);
    end
    wr(`EDTU_CTRL, ctl | 32'h10);
    rc(`EDTU_STATUS, 32'h0);
    report_and_stop();
  end
endmodule // edtu_top_tb_top
`default_nettype wire
